// File: pkg/umx_pkg.sv
// constants and types shared by the multidrop uart extension
package umx_pkg;
    // register byte addresses (low 8 bits of haddr)
    localparam logic [7:0] ADDR_CTRL  = 8'hAC;
    localparam logic [7:0] ADDR_DRVEN = 8'hB0;
    localparam logic [7:0] ADDR_REN   = 8'hB4;
    localparam logic [7:0] ADDR_DRVT  = 8'hB8;
    localparam logic [7:0] ADDR_TURN  = 8'hBC;
    localparam logic [7:0] ADDR_FRAC  = 8'hC0;
    localparam logic [7:0] ADDR_MADR  = 8'hC4;
    localparam logic [7:0] ADDR_TADR  = 8'hC8;
    localparam logic [7:0] ADDR_LCX   = 8'hCC;
    localparam logic [7:0] ADDR_DIV   = 8'hD8;
    localparam logic [7:0] ADDR_STAT  = 8'hDC;
    // field positions
    localparam int CTRL_MODE_EN  = 0;
    localparam int CTRL_XFER_LSB = 3;
    localparam int DRV_LEAD_LSB  = 0;
    localparam int DRV_TAIL_LSB  = 16;
    localparam int TRN_D2L_LSB   = 0;
    localparam int TRN_L2D_LSB   = 16;
    localparam int LCX_NINE      = 0;
    localparam int LCX_MATCH     = 1;
    localparam int LCX_SEND      = 2;
    localparam int FRAC_W        = 4;
    // reset values
    localparam logic [15:0] DIV_RST  = 16'h0001;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    // listen-to-drive gap additions by lead time
    localparam logic [18:0] GAP_ADD_LEAD0 = 19'h00003;
    localparam logic [18:0] GAP_ADD_LEAD1 = 19'h00002;
    localparam logic [18:0] GAP_ADD_LONG  = 19'h00001;
    // full duplex and half duplex transfer modes
    localparam logic [1:0] XM_FULL   = 2'h0;
    localparam logic [1:0] XM_SWITCH = 2'h2;

    typedef enum logic [2:0] {
        ST_LISTEN, ST_L2D, ST_LEAD, ST_DRIVE, ST_TAIL, ST_D2L
    } umx_dir_t;

    // one received character from the core receiver
    typedef struct packed {
        logic       valid;
        logic [8:0] data;
    } umx_char_t;

    // software visible settings
    typedef struct packed {
        logic              mode_en;
        logic [1:0]        xfer;
        logic              drv_bit;
        logic              ren_bit;
        logic [7:0]        lead;
        logic [7:0]        tail;
        logic [15:0]       d2l;
        logic [15:0]       l2d;
        logic [FRAC_W-1:0] frac;
        logic [15:0]       div;
        logic [7:0]        madr;
        logic [7:0]        tadr;
        logic              nine;
        logic              match;
        logic              send;
    } umx_regs_t;
endpackage : umx_pkg

// File: rtl/umx_top.sv
// multidrop uart extension: direction control, fractional baud, 9-bit addressing
//
// What this block does
// RL1 - listen enable output follows software receive bit; mode 2 holds it on in the listen state regardless of the bit
// RL2 - without multidrop option, its registers read zero
// RL3 - hold driver enable for tail time after stop
// RL4 - wait lead time after driver enable rises
// RL5 - transmit starts only after internal transmit enable
// RL6 - gap between listen drop and drive rise
// RL7 - gap adds three, two or one by lead
// RL8 - drive-to-listen gap is programmed value plus one
// RL9 - fraction over sixteen adds to integer divisor
// RL10 - without fraction option, fraction reads zero
// RL11 - address characters compared with match register
// RL12 - after match accept data until next address
// RL13 - filtering only with filter and nine-bit set
// RL14 - software keeps match address steady during reception
// RL15 - send request transmits address character from register
// RL16 - software sends data through holding register only
// RL17 - send request clears when address starts out
// RL18 - mode bit clear keeps point-to-point, enables inert
// RL19 - gaps ignored in full duplex mode zero
// RL20 - nine-bit enable widens transmit and receive characters
// RL21 - without filter every nine-bit character is stored
// RL22 - delays are down-counters ticking each serial clock
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
module umx_top
    import umx_pkg::*;
#(
    parameter bit CFG_MULTIDROP_PRESENT = 1'b1,
    parameter bit CFG_NINE_BIT_PRESENT  = 1'b1,
    parameter bit CFG_FRAC_PRESENT      = 1'b1
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // core transmitter side
    input  wire logic        tx_pending_in,
    input  wire logic        tx_stop_end_in,
    input  wire logic        tx_ready_in,
    output logic             tx_enable_out,
    output logic             tx_addr_go,
    output logic [8:0]       tx_addr_char,
    // core receiver side
    input  wire umx_char_t   rx_char_in,
    input  wire logic        rx_busy_in,
    output logic             rx_store,
    output logic [8:0]       rx_store_data,
    output logic             nine_bit_enable,
    // baud generator
    output logic             baud_tick,
    // line transceiver
    output logic             driver_enable_out,
    output logic             listen_enable_out
);
    // bus pipeline
    logic       wr_pend_r, wr_pend_nxt;
    logic [7:0] wr_addr_r, wr_addr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic       addr_ph;
    umx_regs_t  regs_r, regs_nxt;
    // direction control
    umx_dir_t   st_r, st_nxt;
    logic [18:0] cnt_r, cnt_nxt;
    logic       drv_r, drv_nxt, lsn_r, lsn_nxt, txen_r, txen_nxt;
    logic       go_r, go_nxt;
    logic [8:0] char_r, char_nxt;
    // baud generator
    logic [15:0] bcnt_r, bcnt_nxt;
    logic [FRAC_W-1:0] facc_r, facc_nxt;
    logic       btick_r, btick_nxt;
    // receive filter
    logic       matched_r, matched_nxt;
    logic       rxw_r, rxw_nxt;
    logic [8:0] rxd_r, rxd_nxt;
    // derived
    logic       md_on, gaps_on, filter_on, want_tx, go_cond;
    logic [18:0] gap_add;

    assign md_on     = regs_r.mode_en & CFG_MULTIDROP_PRESENT; // RL18
    assign gaps_on   = md_on && (regs_r.xfer != XM_FULL); // RL19
    assign filter_on = regs_r.match & regs_r.nine; // RL13
    assign want_tx   = tx_pending_in | (regs_r.send & regs_r.nine);
    assign go_cond   = txen_r & tx_ready_in & regs_r.send & regs_r.nine; // RL5
    assign addr_ph   = hsel & htrans[1] & hready;

    // read mux: absent options read zero, reserved bits zero
    function automatic logic [31:0] rd_word(input logic [7:0] a, input umx_regs_t r,
                                             input logic ds, input logic dv, input logic lv,
                                             input logic mt);
        logic [31:0] w;
        w = WORD_RST;
        case (a)
            ADDR_CTRL:  w = {27'h0, r.xfer, 2'h0, r.mode_en};
            ADDR_DRVEN: w = {31'h0, r.drv_bit};
            ADDR_REN:   w = {31'h0, r.ren_bit}; // RL1
            ADDR_DRVT:  w = {8'h0, r.tail, 8'h0, r.lead};
            ADDR_TURN:  w = {r.l2d, r.d2l};
            ADDR_FRAC:  w = CFG_FRAC_PRESENT ? {{(32-FRAC_W){1'b0}}, r.frac} : WORD_RST; // RL10
            ADDR_MADR:  w = {24'h0, r.madr};
            ADDR_TADR:  w = {24'h0, r.tadr};
            ADDR_LCX:   w = {29'h0, r.send, r.match, r.nine};
            ADDR_DIV:   w = {16'h0, r.div};
            ADDR_STAT:  w = {26'h0, mt, lv, dv, 2'h0, ds};
            default:    w = WORD_RST;
        endcase
        if (!CFG_MULTIDROP_PRESENT && (a == ADDR_CTRL || a == ADDR_DRVEN || a == ADDR_REN ||
                                       a == ADDR_DRVT || a == ADDR_TURN)) begin
            w = WORD_RST; // RL2
        end
        if (!CFG_NINE_BIT_PRESENT && (a == ADDR_MADR || a == ADDR_TADR || a == ADDR_LCX)) begin
            w = WORD_RST;
        end
        return w;
    endfunction : rd_word

    // bus slave and register file; zero wait states, read data sampled in address phase
    always_comb begin
        wr_pend_nxt = addr_ph & hwrite;
        wr_addr_nxt = addr_ph ? haddr[7:0] : wr_addr_r;
        hrdata_nxt  = (addr_ph && !hwrite) ?
                      rd_word(haddr[7:0], regs_r, st_r == ST_DRIVE, drv_r, lsn_r, matched_r) : hrdata_r;
        regs_nxt    = regs_r;
        if (go_r) begin
            regs_nxt.send = 1'b0; // RL17
        end
        if (wr_pend_r) begin
            case (wr_addr_r)
                ADDR_CTRL: begin
                    regs_nxt.mode_en = hwdata[CTRL_MODE_EN];
                    regs_nxt.xfer    = hwdata[CTRL_XFER_LSB +: 2];
                end
                ADDR_DRVEN: regs_nxt.drv_bit = hwdata[0];
                ADDR_REN:   regs_nxt.ren_bit = hwdata[0];
                ADDR_DRVT: begin
                    regs_nxt.lead = hwdata[DRV_LEAD_LSB +: 8];
                    regs_nxt.tail = hwdata[DRV_TAIL_LSB +: 8];
                end
                ADDR_TURN: begin
                    regs_nxt.d2l = hwdata[TRN_D2L_LSB +: 16];
                    regs_nxt.l2d = hwdata[TRN_L2D_LSB +: 16];
                end
                ADDR_FRAC: regs_nxt.frac = CFG_FRAC_PRESENT ? hwdata[FRAC_W-1:0] : regs_r.frac;
                ADDR_MADR: regs_nxt.madr = hwdata[7:0]; // RL14
                ADDR_TADR: regs_nxt.tadr = hwdata[7:0];
                ADDR_LCX: begin
                    regs_nxt.nine  = hwdata[LCX_NINE];
                    regs_nxt.match = hwdata[LCX_MATCH];
                    // a software set wins over a clear in the same cycle
                    regs_nxt.send  = hwdata[LCX_SEND] | regs_nxt.send;
                end
                ADDR_DIV: regs_nxt.div = hwdata[15:0];
                default: ;
            endcase
        end
        if (!CFG_MULTIDROP_PRESENT) begin
            regs_nxt.mode_en = 1'b0;
        end
        if (!CFG_NINE_BIT_PRESENT) begin
            regs_nxt.nine = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r  <= WORD_RST;
            regs_r    <= '0;
            regs_r.div <= DIV_RST;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            hrdata_r  <= hrdata_nxt;
            regs_r    <= regs_nxt;
        end
    end

    // listen-to-drive gap depends on lead time
    always_comb begin
        if (regs_r.lead == 8'h00) begin
            gap_add = GAP_ADD_LEAD0; // RL7
        end else if (regs_r.lead == 8'h01) begin
            gap_add = GAP_ADD_LEAD1;
        end else begin
            gap_add = GAP_ADD_LONG;
        end
    end

    // direction sequencer; one counter, loaded at state entry, counts down each serial clock
    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = (cnt_r != 19'h0) ? cnt_r - 19'h1 : cnt_r; // RL22
        go_nxt   = 1'b0;
        char_nxt = char_r;
        case (st_r)
            ST_LISTEN: begin
                if (md_on && !gaps_on && regs_r.drv_bit) begin
                    // full duplex: no turnaround, lead time only
                    st_nxt  = (regs_r.lead == 8'h00) ? ST_DRIVE : ST_LEAD;
                    cnt_nxt = {11'h0, regs_r.lead} - 19'h1;
                end else if (gaps_on && want_tx && !rx_busy_in &&
                             (regs_r.xfer == XM_SWITCH || regs_r.drv_bit)) begin
                    st_nxt  = ST_L2D;
                    cnt_nxt = {3'h0, regs_r.l2d} + gap_add - 19'h1; // RL6
                end
            end
            ST_L2D: begin
                if (cnt_r == 19'h0) begin
                    st_nxt  = (regs_r.lead == 8'h00) ? ST_DRIVE : ST_LEAD;
                    cnt_nxt = {11'h0, regs_r.lead} - 19'h1;
                end
            end
            ST_LEAD: begin
                if (cnt_r == 19'h0) begin
                    st_nxt = ST_DRIVE; // RL4
                end
            end
            ST_DRIVE: begin
                if (!gaps_on && !regs_r.drv_bit) begin
                    st_nxt = ST_LISTEN;
                end else if (gaps_on && tx_stop_end_in && !want_tx) begin
                    st_nxt  = (regs_r.tail == 8'h00) ? ST_D2L : ST_TAIL;
                    cnt_nxt = (regs_r.tail == 8'h00) ? {3'h0, regs_r.d2l} :
                              {11'h0, regs_r.tail} - 19'h1;
                end
            end
            ST_TAIL: begin
                if (cnt_r == 19'h0) begin
                    st_nxt  = ST_D2L; // RL3
                    cnt_nxt = {3'h0, regs_r.d2l}; // RL8
                end
            end
            ST_D2L: begin
                if (cnt_r == 19'h0) begin
                    st_nxt = ST_LISTEN;
                end
            end
            default: st_nxt = ST_LISTEN;
        endcase
        if (!md_on) begin
            st_nxt = ST_LISTEN; // RL18
        end
        // outputs follow the next state so that they leave flops
        drv_nxt  = md_on && (st_nxt == ST_LEAD || st_nxt == ST_DRIVE || st_nxt == ST_TAIL);
        txen_nxt = !md_on || (st_nxt == ST_DRIVE); // RL5
        if (!md_on) begin
            lsn_nxt = 1'b0;
        end else if (!gaps_on) begin
            lsn_nxt = regs_r.ren_bit; // RL1
        end else if (st_nxt == ST_LISTEN) begin
            lsn_nxt = (regs_r.xfer == XM_SWITCH) | regs_r.ren_bit;
        end else begin
            lsn_nxt = 1'b0;
        end
        // address character issue, one pulse per request
        if (go_cond && !go_r) begin
            go_nxt   = 1'b1;
            char_nxt = {1'b1, regs_r.tadr}; // RL15
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_r   <= ST_LISTEN;
            cnt_r  <= 19'h0;
            drv_r  <= 1'b0;
            lsn_r  <= 1'b0;
            txen_r <= 1'b1;
            go_r   <= 1'b0;
            char_r <= 9'h000;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            drv_r  <= drv_nxt;
            lsn_r  <= lsn_nxt;
            txen_r <= txen_nxt;
            go_r   <= go_nxt;
            char_r <= char_nxt;
        end
    end

    // fractional baud: the fraction accumulates, each carry stretches one period by a cycle
    always_comb begin
        btick_nxt = 1'b0;
        bcnt_nxt  = bcnt_r - 16'h1;
        facc_nxt  = facc_r;
        if (bcnt_r <= 16'h1) begin
            btick_nxt = 1'b1;
            facc_nxt  = facc_r + regs_r.frac; // RL9
            bcnt_nxt  = regs_r.div + {15'h0, (facc_nxt < facc_r)};
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bcnt_r  <= DIV_RST;
            facc_r  <= '0;
            btick_r <= 1'b0;
        end else begin
            bcnt_r  <= bcnt_nxt;
            facc_r  <= facc_nxt;
            btick_r <= btick_nxt;
        end
    end

    // receive address filter; with filtering on, address characters are not stored, matched or not
    always_comb begin
        matched_nxt = matched_r;
        rxw_nxt     = 1'b0;
        rxd_nxt     = rxd_r;
        if (rx_char_in.valid) begin
            rxd_nxt = regs_r.nine ? rx_char_in.data : {1'b0, rx_char_in.data[7:0]}; // RL20
            if (!filter_on) begin
                rxw_nxt = 1'b1; // RL21
            end else if (rx_char_in.data[8]) begin
                matched_nxt = (rx_char_in.data[7:0] == regs_r.madr); // RL11
            end else begin
                rxw_nxt = matched_r; // RL12
            end
        end
        if (!filter_on) begin
            matched_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            matched_r <= 1'b0;
            rxw_r     <= 1'b0;
            rxd_r     <= 9'h000;
        end else begin
            matched_r <= matched_nxt;
            rxw_r     <= rxw_nxt;
            rxd_r     <= rxd_nxt;
        end
    end

    // outputs, all from flops except the tied-off hreadyout and hresp
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign hrdata            = hrdata_r;
    assign tx_enable_out     = txen_r;
    assign tx_addr_go        = go_r;
    assign tx_addr_char      = char_r;
    assign rx_store          = rxw_r;
    assign rx_store_data     = rxd_r;
    assign nine_bit_enable   = regs_r.nine;
    assign baud_tick         = btick_r;
    assign driver_enable_out = drv_r;
    assign listen_enable_out = lsn_r;

    // checks
    sequence s_drive_end;
        st_r == ST_TAIL && cnt_r == 19'h0;
    endsequence

    chk_listen_follow: assert property (@(posedge clk_sys) disable iff (!resetn) // RL1
        md_on && !gaps_on && $stable(regs_r) |=> lsn_r == $past(regs_r.ren_bit))
        else $error("listen enable does not follow software bit");
    chk_no_overlap: assert property (@(posedge clk_sys) disable iff (!resetn) // RL6
        gaps_on && $past(gaps_on) && drv_r |-> !lsn_r)
        else $error("drive and listen enabled together");
    chk_lead_before_tx: assert property (@(posedge clk_sys) disable iff (!resetn) // RL4
        $rose(txen_r) && md_on |-> drv_r)
        else $error("transmit enable without driver enable");
    chk_tail_drop: assert property (@(posedge clk_sys) disable iff (!resetn) // RL3
        s_drive_end ##1 md_on |-> !drv_r)
        else $error("driver enable held past tail time");
    chk_d2l_gap: assert property (@(posedge clk_sys) disable iff (!resetn) // RL8
        $fell(drv_r) && gaps_on |-> !lsn_r)
        else $error("listen raised without turnaround gap");
    chk_send_clear: assert property (@(posedge clk_sys) disable iff (!resetn) // RL17
        go_r && !(wr_pend_r && wr_addr_r == ADDR_LCX) |=> !regs_r.send)
        else $error("send request not cleared");
    chk_addr_char: assert property (@(posedge clk_sys) disable iff (!resetn) // RL15
        go_r |-> char_r == {1'b1, $past(regs_r.tadr)})
        else $error("address character wrong");
    chk_filter_data: assert property (@(posedge clk_sys) disable iff (!resetn) // RL12
        rx_char_in.valid && filter_on && !rx_char_in.data[8] && !matched_r |=> !rxw_r)
        else $error("unmatched data stored");
    chk_absent_zero: assert property (@(posedge clk_sys) disable iff (!resetn) // RL2
        !CFG_MULTIDROP_PRESENT && addr_ph && !hwrite && haddr[7:0] == ADDR_TURN |=> hrdata_r == WORD_RST)
        else $error("absent register reads nonzero");
endmodule : umx_top

// File: verification/umx_core_model.sv
// stand-in for the core transmitter and receiver around the extension block
`timescale 1ns/10ps
module umx_core_model
    import umx_pkg::*;
#(
    parameter int CHAR_LEN = 10
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    // bench requests
    input  wire logic       tx_go,
    input  wire logic       rx_go,
    input  wire logic [8:0] rx_data,
    // extension block side
    input  wire logic       tx_enable_out,
    output logic            tx_pending_in,
    output logic            tx_stop_end_in,
    output logic            tx_ready_in,
    output umx_char_t       rx_char_in,
    output logic            rx_busy_in
);
    logic [7:0] tx_cnt_r;
    logic [7:0] rx_cnt_r;
    logic [8:0] rx_hold_r;
    // ready only while no character is on the line
    assign tx_ready_in = (tx_cnt_r == 8'h00);
    assign rx_busy_in  = (rx_cnt_r != 8'h00);
    // one character per request; idle data shows the inverse so stale bits never pass
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_cnt_r       <= 8'h00;
            rx_cnt_r       <= 8'h00;
            rx_hold_r      <= 9'h000;
            tx_pending_in  <= 1'b0;
            tx_stop_end_in <= 1'b0;
            rx_char_in     <= '0;
        end else begin
            tx_stop_end_in <= 1'b0;
            rx_char_in     <= {1'b0, ~rx_hold_r};
            if (tx_go) begin
                tx_pending_in <= 1'b1;
            end
            if (tx_pending_in && tx_enable_out && tx_cnt_r == 8'h00) begin
                tx_cnt_r <= 8'(CHAR_LEN);
            end else if (tx_cnt_r == 8'h01) begin
                tx_cnt_r       <= 8'h00;
                tx_stop_end_in <= 1'b1;
                tx_pending_in  <= 1'b0;
            end else if (tx_cnt_r != 8'h00) begin
                tx_cnt_r <= tx_cnt_r - 8'h01;
            end
            if (rx_go) begin
                rx_cnt_r  <= 8'(CHAR_LEN);
                rx_hold_r <= rx_data;
            end else if (rx_cnt_r == 8'h01) begin
                rx_cnt_r   <= 8'h00;
                rx_char_in <= {1'b1, rx_hold_r};
            end else if (rx_cnt_r != 8'h00) begin
                rx_cnt_r <= rx_cnt_r - 8'h01;
            end
        end
    end
endmodule : umx_core_model

// File: verification/testbench.sv
// self-checking bench for the multidrop uart extension
`timescale 1ns/10ps
module testbench;
    import umx_pkg::*;
    localparam int CL = 10;
    logic        clk_sys, resetn, hsel, hwrite, hready, hreadyout, hresp, tx_go, rx_go;
    logic [31:0] haddr, hwdata, hrdata, hrdata2, rv, rv2;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        tx_pending_in, tx_stop_end_in, tx_ready_in, tx_enable_out, tx_addr_go, rx_busy_in;
    logic        rx_store, nine_bit_enable, baud_tick, driver_enable_out, listen_enable_out;
    logic [8:0]  tx_addr_char, rx_store_data, rx_data, ac;
    umx_char_t   rx_char_in;
    logic [8:0]  st_q[$];
    logic        le_q, dv_q, te_q;
    int          err_count, n_checks, cyc, ag, nt, t_tick, t_span, t_lf, t_lr, t_dr, t_df, t_tr, t_st;
    assign hready = hreadyout;
    umx_top umx_top_inst (.*);
    // second copy built without the multidrop and fraction options
    umx_top #(.CFG_MULTIDROP_PRESENT(1'b0), .CFG_FRAC_PRESENT(1'b0)) umx_top_inst_min (.*, .hrdata(hrdata2),
        .hreadyout(), .hresp(), .tx_enable_out(), .tx_addr_go(), .tx_addr_char(), .rx_store(),
        .rx_store_data(), .nine_bit_enable(), .baud_tick(), .driver_enable_out(), .listen_enable_out());
    umx_core_model #(.CHAR_LEN(CL)) umx_core_model_inst (.*);
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    // one ahb-lite single word transfer, entered and left just after a rising edge
    task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr_en;
        hsize  <= 3'h2;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rv  = hrdata;
        rv2 = hrdata2;
        check("response", hresp, 32'h0);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask : rd
    task automatic ended(input string s);
        $display("test %s finished", s);
    endtask : ended
    // edge times and captured events; all sampled alike so differences are exact
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        le_q <= listen_enable_out;
        dv_q <= driver_enable_out;
        te_q <= tx_enable_out;
        if (le_q && !listen_enable_out) t_lf = cyc;
        if (!le_q && listen_enable_out) t_lr = cyc;
        if (!dv_q && driver_enable_out) t_dr = cyc;
        if (dv_q && !driver_enable_out) t_df = cyc;
        if (!te_q && tx_enable_out) t_tr = cyc;
        if (tx_stop_end_in) t_st = cyc;
        if (rx_store) st_q.push_back(rx_store_data);
        if (tx_addr_go) begin
            ag++;
            ac = tx_addr_char;
        end
        if (baud_tick) begin
            nt++;
            if (nt == 1) t_tick = cyc;
            if (nt == 17) t_span = cyc - t_tick;
        end
        if (cyc == 40000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic t_regs();
        logic [7:0]  ad[6] = '{ADDR_REN, ADDR_DRVT, ADDR_TURN, ADDR_FRAC, ADDR_MADR, ADDR_TADR};
        logic [31:0] ex[6] = '{32'h1, 32'h00FF00FF, 32'hFFFFFFFF, 32'hF, 32'hFF, 32'hFF};
        for (int i = 0; i < 6; i++) begin
            rd(ad[i]);
            check("reset value", rv, 32'h0);
            wr(ad[i], 32'hFFFFFFFF);
            rd(ad[i]);
            check("readback", rv, ex[i]);
            check("absent option", rv2, (i < 4) ? 32'h0 : ex[i]);
        end
        wr(8'hF0, 32'hFFFFFFFF);
        rd(8'hF0);
        check("unmapped", rv, 32'h0);
        ended("registers");
    endtask : t_regs
    task automatic t_full();
        wr(ADDR_DRVT, 32'h00000003);
        wr(ADDR_TURN, 32'h00640064);
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_DRVEN, 32'h1);
        repeat (8) @(posedge clk_sys);
        check("mode 0 drive", driver_enable_out, 32'h1);
        check("mode 0 listen", listen_enable_out, 32'h1);
        check("lead in mode 0", t_tr - t_dr, 32'd3);
        wr(ADDR_REN, 32'h0);
        repeat (3) @(posedge clk_sys);
        check("listen off", listen_enable_out, 32'h0);
        wr(ADDR_CTRL, 32'h0);
        repeat (3) @(posedge clk_sys);
        check("mode off drive", driver_enable_out, 32'h0);
        check("mode off tx en", tx_enable_out, 32'h1);
        ended("full duplex");
    endtask : t_full
    // modes 1 and 2: tail 3, listen-to-drive 4, drive-to-listen 5
    task automatic t_turn(input int lead, input int add, input int ctl);
        wr(ADDR_DRVT, 32'h00030000 | lead);
        wr(ADDR_TURN, 32'h00040005);
        wr(ADDR_REN, 32'h1);
        wr(ADDR_CTRL, ctl);
        repeat (30) @(posedge clk_sys);
        check("listening", listen_enable_out, 32'h1);
        t_lr = 0;
        tx_go <= 1'b1;
        @(posedge clk_sys);
        tx_go <= 1'b0;
        for (int i = 0; i < 300 && t_lr == 0; i++) @(posedge clk_sys);
        check("listen to drive", t_dr - t_lf, 4 + add);
        check("lead", t_tr - t_dr, lead);
        check("data after en", t_st > t_tr, 32'h1);
        check("tail", t_df - t_st, 32'd4);
        check("drive to listen", t_lr - t_df, 32'd6);
        wr(ADDR_CTRL, 32'h0);
        ended("turnaround");
    endtask : t_turn
    task automatic t_addr();
        wr(ADDR_TADR, 32'hA7);
        ag = 0;
        wr(ADDR_LCX, 32'h5);
        for (int i = 0; i < 50 && ag == 0; i++) @(posedge clk_sys);
        repeat (3) @(posedge clk_sys);
        check("go count", ag, 32'h1);
        check("address char", ac, 32'h1A7);
        check("nine bit out", nine_bit_enable, 32'h1);
        rd(ADDR_LCX);
        check("send cleared", rv, 32'h1);
        ended("address send");
    endtask : t_addr
    task automatic t_rx();
        logic [31:0] lx[8] = '{32'h2, 32'h3, 32'h3, 32'h3, 32'h3, 32'h3, 32'h3, 32'h1};
        logic [8:0]  sq[8] = '{9'h1A5, 9'h15A, 9'h033, 9'h1A5, 9'h044, 9'h15A, 9'h055, 9'h1A5};
        logic [8:0]  ex[4] = '{9'h0A5, 9'h033, 9'h055, 9'h1A5};
        wr(ADDR_MADR, 32'h5A);
        st_q.delete();
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_LCX, lx[i]);
            rx_data <= sq[i];
            rx_go   <= 1'b1;
            @(posedge clk_sys);
            rx_go <= 1'b0;
            repeat (CL + 4) @(posedge clk_sys);
        end
        check("stored count", st_q.size(), 32'd4);
        for (int i = 0; i < 4; i++) check("stored char", st_q[i], ex[i]);
        ended("address filter");
    endtask : t_rx
    task automatic t_baud();
        wr(ADDR_DIV, 32'h4);
        wr(ADDR_FRAC, 32'h8);
        repeat (10) @(posedge clk_sys);
        nt = 0;
        for (int i = 0; i < 300 && nt < 17; i++) @(posedge clk_sys);
        check("baud span", t_span, 32'd72);
        ended("fraction");
    endtask : t_baud
    initial begin
        {hsel, hwrite, tx_go, rx_go, resetn, haddr, hwdata, htrans, hsize, rx_data} = '0;
        {err_count, n_checks, cyc, ag, nt, t_tick, t_span, t_lf, t_lr, t_dr, t_df, t_tr, t_st} = '0;
        repeat (3) @(posedge clk_sys);
        check("reset tx enable", tx_enable_out, 32'h1);
        check("reset listen", listen_enable_out, 32'h0);
        resetn <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_full();
        t_turn(0, 3, 'h11);
        t_turn(1, 2, 'h11);
        t_turn(5, 1, 'h09);
        t_addr();
        t_rx();
        t_baud();
        complete_run();
    end
endmodule : testbench
